//--- hw/ccr_map.svh
// register offsets, field positions, reset values and timing counts of the converter option registers
// assumes a 100 MHz clock; included by bare name from the package and the modules
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH
`define CCR_ADDR_W 8
`define CCR_OFS_OPTION 8'h12
`define CCR_OFS_INPATH 8'h13
// converter_option_control fields
`define CCR_B_GATE_MASTER_OFF 7
`define CCR_B_LIGHT_LOAD_OFF 4
`define CCR_B_SHIP_EXIT_HOLD 3
`define CCR_B_DROPOUT_OFF 2
`define CCR_B_OOA_OFF 0
`define CCR_OPTION_RST 8'h00
`define CCR_OPTION_WMASK 8'h9D
// input_path_protection_control fields
`define CCR_B_IN2_GATE 7
`define CCR_B_IN1_GATE 6
`define CCR_B_RATE_SEL 5
`define CCR_B_IND_OFF 4
`define CCR_B_SHORT_OFF 3
`define CCR_B_FORCE_DET 1
`define CCR_B_OCP_ON 0
`define CCR_INPATH_WMASK 8'hFB
// watchdog period codes and default
`define CCR_WD_CODE_DEF 3'h5
`define CCR_CLK_HZ 100000000
// one-millisecond tick, 100000 cycles of 10 ns
`define CCR_TICK_CYC (`CCR_CLK_HZ / 1000)
`define CCR_MS_0P5 500
`define CCR_MS_1 1000
`define CCR_MS_2 2000
`define CCR_MS_20 20000
`define CCR_MS_40 40000
`define CCR_MS_80 80000
`define CCR_MS_160 160000
`endif

//--- hw/ccr_pkg.sv
// types shared by the converter option register bank
// assumes ccr_map.svh is on the include path
`include "ccr_map.svh"
package ccr_pkg;
   typedef logic [7:0] ccr_byte_t;
   typedef enum logic [1:0] {
      CCR_DET_IDLE = 2'b00,
      CCR_DET_REQ = 2'b01,
      CCR_DET_WAIT = 2'b10
   } ccr_det_e;
endpackage : ccr_pkg

//--- hw/ccr_regs.sv
// converter option and input path protection registers at offsets 12h and 13h
// assumes a decoded byte port from the serial interface, synchronous to clock,
// and status and handshake inputs from the converter, detector and ADC
// Function
// - master gate disable forces both input gate driver enables to zero
// - second input gate enable locked zero when its FET pair is absent
// - first input gate enable locked zero when its FET pair is absent
// - switching rate bit loads from strap pin; 0 fast, 1 half rate
// - indicator pin disable bit, reset by watchdog and register reset
// - rail short protection disable bit, reset by register reset only
// - forced detection write of one accepted only if battery above minimum
// - forced detection stops switching, measures input, updates limit, then clears
// - input overcurrent protect enable, resets to one on register reset
// - light-load pulse mode disable bit, reset by register reset
// - ship exit hold time select: 0 one second, 1 fifteen ms
// - precharge dropout disable bit, reset by watchdog and register reset
// - out-of-audio disable bit, reset by register reset
// - watchdog with three-bit period, zero disables, default forty seconds
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_regs
   import ccr_pkg::*;
#(
   parameter int TICK_CYC = `CCR_TICK_CYC
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic reg_reset,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] wd_period,
   input wire logic wd_kick,
   input wire logic strap_low_rate,
   input wire logic por_done,
   input wire logic in1_fets_present,
   input wire logic in2_fets_present,
   input wire logic battery_above_minimum,
   input wire logic detect_done,
   output logic gate_driver_master_disable,
   output logic input1_gate_driver_on,
   output logic input2_gate_driver_on,
   output logic switching_rate_select,
   output logic indicator_pin_off,
   output logic rail_short_protect_off,
   output logic input_overcurrent_protect_on,
   output logic light_load_pulse_mode_off,
   output logic ship_exit_hold_time,
   output logic precharge_dropout_mode_off,
   output logic out_of_audio_off,
   output logic converter_halt,
   output logic input_measure_req,
   output logic input_limit_update
);
   // ***************************************************
   // storage and decode
   // ***************************************************
   ccr_byte_t option_reg;
   ccr_byte_t inpath_reg;
   logic in1_ok_reg;
   logic in2_ok_reg;
   logic strap_taken_reg;
   ccr_det_e det_reg;
   logic wd_expired;
   logic wr_opt;
   logic wr_inp;
   ccr_byte_t opt_view;
   ccr_byte_t inp_view;

   assign wr_opt = reg_wr && reg_addr == `CCR_OFS_OPTION;
   assign wr_inp = reg_wr && reg_addr == `CCR_OFS_INPATH;

   ccr_watchdog #(
      .TICK_CYC(TICK_CYC)
   ) u_wd (
      .clock(clock),
      .arst_n(arst_n),
      .period_code(wd_period),
      .kick(wd_kick || reg_reset),
      .expired(wd_expired)
   );

   // ***************************************************
   // power-on captures
   // ***************************************************
   // strap and FET presence are sampled once when power-on detection ends
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         in1_ok_reg <= 1'b0;
         in2_ok_reg <= 1'b0;
         strap_taken_reg <= 1'b0;
      end else if (por_done && !strap_taken_reg) begin
         in1_ok_reg <= in1_fets_present;
         in2_ok_reg <= in2_fets_present;
         strap_taken_reg <= 1'b1;
      end
   end

   // ***************************************************
   // converter_option_control
   // ***************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         option_reg <= `CCR_OPTION_RST;
      end else if (reg_reset) begin
         // master gate disable has no register reset
         option_reg <= option_reg & (8'h01 << `CCR_B_GATE_MASTER_OFF);
      end else if (wr_opt) begin
         option_reg <= reg_wdata & `CCR_OPTION_WMASK;
      end else if (wd_expired) begin
         option_reg[`CCR_B_DROPOUT_OFF] <= 1'b0;
      end
   end

   // ***************************************************
   // input_path_protection_control
   // ***************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         inpath_reg <= 8'h01;
      end else begin
         if (por_done && !strap_taken_reg) begin
            inpath_reg[`CCR_B_RATE_SEL] <= strap_low_rate;
         end
         if (reg_reset) begin
            inpath_reg[`CCR_B_IND_OFF] <= 1'b0;
            inpath_reg[`CCR_B_SHORT_OFF] <= 1'b0;
            inpath_reg[`CCR_B_FORCE_DET] <= 1'b0;
            inpath_reg[`CCR_B_OCP_ON] <= 1'b1;
         end else if (wr_inp) begin
            inpath_reg[`CCR_B_IN2_GATE] <= reg_wdata[`CCR_B_IN2_GATE];
            inpath_reg[`CCR_B_IN1_GATE] <= reg_wdata[`CCR_B_IN1_GATE];
            inpath_reg[`CCR_B_RATE_SEL] <= reg_wdata[`CCR_B_RATE_SEL];
            inpath_reg[`CCR_B_IND_OFF] <= reg_wdata[`CCR_B_IND_OFF];
            inpath_reg[`CCR_B_SHORT_OFF] <= reg_wdata[`CCR_B_SHORT_OFF];
            inpath_reg[`CCR_B_OCP_ON] <= reg_wdata[`CCR_B_OCP_ON];
            // a pending detection is not cancelled by writing zero
            if (reg_wdata[`CCR_B_FORCE_DET] && battery_above_minimum) begin
               inpath_reg[`CCR_B_FORCE_DET] <= 1'b1;
            end else if (det_reg == CCR_DET_WAIT && detect_done) begin
               inpath_reg[`CCR_B_FORCE_DET] <= 1'b0;
            end
         end else begin
            if (wd_expired) begin
               inpath_reg[`CCR_B_IND_OFF] <= 1'b0;
            end
            if (det_reg == CCR_DET_WAIT && detect_done) begin
               inpath_reg[`CCR_B_FORCE_DET] <= 1'b0;
            end
         end
      end
   end

   // ***************************************************
   // forced input-limit detection sequence
   // ***************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         det_reg <= CCR_DET_IDLE;
      end else if (reg_reset) begin
         det_reg <= CCR_DET_IDLE;
      end else begin
         case (det_reg)
            CCR_DET_IDLE: begin
               if (inpath_reg[`CCR_B_FORCE_DET]) begin
                  det_reg <= CCR_DET_REQ;
               end
            end
            CCR_DET_REQ: begin
               det_reg <= CCR_DET_WAIT;
            end
            CCR_DET_WAIT: begin
               if (detect_done) begin
                  det_reg <= CCR_DET_IDLE;
               end
            end
            default: begin
               det_reg <= CCR_DET_IDLE;
            end
         endcase
      end
   end

   // ***************************************************
   // outputs, all registered
   // ***************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         converter_halt <= 1'b0;
         input_measure_req <= 1'b0;
         input_limit_update <= 1'b0;
      end else begin
         converter_halt <= det_reg != CCR_DET_IDLE && !reg_reset;
         input_measure_req <= det_reg == CCR_DET_REQ && !reg_reset;
         input_limit_update <= det_reg == CCR_DET_WAIT && detect_done && !reg_reset;
      end
   end

   // gate enables read back as the forced value, so software sees the lock
   always_comb begin
      opt_view = option_reg & `CCR_OPTION_WMASK;
      inp_view = inpath_reg & `CCR_INPATH_WMASK;
      if (option_reg[`CCR_B_GATE_MASTER_OFF]) begin
         inp_view[`CCR_B_IN2_GATE] = 1'b0;
         inp_view[`CCR_B_IN1_GATE] = 1'b0;
      end
      if (!in2_ok_reg) begin
         inp_view[`CCR_B_IN2_GATE] = 1'b0;
      end
      if (!in1_ok_reg) begin
         inp_view[`CCR_B_IN1_GATE] = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gate_driver_master_disable <= 1'b0;
         input1_gate_driver_on <= 1'b0;
         input2_gate_driver_on <= 1'b0;
         switching_rate_select <= 1'b0;
         indicator_pin_off <= 1'b0;
         rail_short_protect_off <= 1'b0;
         input_overcurrent_protect_on <= 1'b1;
         light_load_pulse_mode_off <= 1'b0;
         ship_exit_hold_time <= 1'b0;
         precharge_dropout_mode_off <= 1'b0;
         out_of_audio_off <= 1'b0;
      end else begin
         gate_driver_master_disable <= opt_view[`CCR_B_GATE_MASTER_OFF];
         input1_gate_driver_on <= inp_view[`CCR_B_IN1_GATE];
         input2_gate_driver_on <= inp_view[`CCR_B_IN2_GATE];
         switching_rate_select <= inp_view[`CCR_B_RATE_SEL];
         indicator_pin_off <= inp_view[`CCR_B_IND_OFF];
         rail_short_protect_off <= inp_view[`CCR_B_SHORT_OFF];
         input_overcurrent_protect_on <= inp_view[`CCR_B_OCP_ON];
         light_load_pulse_mode_off <= opt_view[`CCR_B_LIGHT_LOAD_OFF];
         ship_exit_hold_time <= opt_view[`CCR_B_SHIP_EXIT_HOLD];
         precharge_dropout_mode_off <= opt_view[`CCR_B_DROPOUT_OFF];
         out_of_audio_off <= opt_view[`CCR_B_OOA_OFF];
      end
   end

   // read data registered one cycle after the read strobe; other offsets read zero
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `CCR_OFS_OPTION: reg_rdata <= opt_view;
            `CCR_OFS_INPATH: reg_rdata <= inp_view;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule : ccr_regs

//--- hw/ccr_watchdog.sv
// watchdog for the register bank: millisecond divider and period counter
// assumes kick is a one-cycle pulse from the serial register port
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_watchdog
   import ccr_pkg::*;
#(
   parameter int TICK_CYC = `CCR_TICK_CYC
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [2:0] period_code,
   input wire logic kick,
   output logic expired
);
   logic [16:0] div_reg;
   logic tick_reg;
   logic [17:0] ms_reg;
   logic [17:0] limit;

   always_comb begin
      case (period_code)
         3'h1: limit = 18'(`CCR_MS_0P5);
         3'h2: limit = 18'(`CCR_MS_1);
         3'h3: limit = 18'(`CCR_MS_2);
         3'h4: limit = 18'(`CCR_MS_20);
         3'h5: limit = 18'(`CCR_MS_40);
         3'h6: limit = 18'(`CCR_MS_80);
         3'h7: limit = 18'(`CCR_MS_160);
         default: limit = 18'h0_0000;
      endcase
   end

   // one-cycle enable each millisecond, no second clock
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         div_reg <= 17'h0_0000;
         tick_reg <= 1'b0;
      end else if (div_reg == 17'(TICK_CYC - 1)) begin
         div_reg <= 17'h0_0000;
         tick_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + 17'h0_0001;
         tick_reg <= 1'b0;
      end
   end

   // code 0 disables; expiry is a single pulse then counting restarts
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ms_reg <= 18'h0_0000;
         expired <= 1'b0;
      end else if (kick || period_code == 3'h0) begin
         ms_reg <= 18'h0_0000;
         expired <= 1'b0;
      end else if (tick_reg && ms_reg + 18'h0_0001 >= limit) begin
         ms_reg <= 18'h0_0000;
         expired <= 1'b1;
      end else begin
         ms_reg <= tick_reg ? ms_reg + 18'h0_0001 : ms_reg;
         expired <= 1'b0;
      end
   end
endmodule : ccr_watchdog

//--- verification/ccr_adc_model.sv
// stand-in for the detector and converter adc: answers each request with a done pulse
// assumes requests are one-cycle pulses; the bench sets the conversion delay
`timescale 1ns/1ps
module ccr_adc_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic input_measure_req,
   input wire logic [7:0] delay,
   output logic detect_done
);
   int cnt;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 0;
         detect_done <= 1'b0;
      end else begin
         detect_done <= (cnt == 1);
         if (input_measure_req) begin
            cnt <= int'(delay) + 1;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule : ccr_adc_model

//--- verification/ccr_regs_monitor.sv
// assertions on the ports of the converter option register bank
// assumes binding to ccr_regs; outputs settle within three edges of a write
`timescale 1ns/1ps
module ccr_regs_monitor
   import ccr_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic reg_reset,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic por_done,
   input wire logic in1_fets_present,
   input wire logic in2_fets_present,
   input wire logic battery_above_minimum,
   input wire logic detect_done,
   input wire logic gate_driver_master_disable,
   input wire logic input1_gate_driver_on,
   input wire logic input2_gate_driver_on,
   input wire logic switching_rate_select,
   input wire logic indicator_pin_off,
   input wire logic rail_short_protect_off,
   input wire logic input_overcurrent_protect_on,
   input wire logic light_load_pulse_mode_off,
   input wire logic ship_exit_hold_time,
   input wire logic precharge_dropout_mode_off,
   input wire logic out_of_audio_off,
   input wire logic converter_halt,
   input wire logic input_measure_req,
   input wire logic input_limit_update
);
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   logic seen_reg, abs1_reg, abs2_reg;
   // absent until the first power-on flag, as the bank itself assumes
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         seen_reg <= 1'b0;
         abs1_reg <= 1'b1;
         abs2_reg <= 1'b1;
      end else if (por_done && !seen_reg) begin
         seen_reg <= 1'b1;
         abs1_reg <= !in1_fets_present;
         abs2_reg <= !in2_fets_present;
      end
   end
   // two idle edges so either output latency lands before the check
   sequence quiet_s;
      !(reg_wr || reg_reset) [*2];
   endsequence
   sequence opt_wr_s;
      reg_wr && reg_addr == 8'h12 ##1 quiet_s;
   endsequence
   sequence inp_wr_s;
      reg_wr && reg_addr == 8'h13 ##1 quiet_s;
   endsequence
   sequence force_s;
      reg_wr && reg_addr == 8'h13 && reg_wdata[1] && !converter_halt;
   endsequence
   gate_mask_a: assert property (gate_driver_master_disable |-> !input1_gate_driver_on && !input2_gate_driver_on)
      else $error("gate enable on while masked");
   in2_lock_a: assert property (abs2_reg |-> !input2_gate_driver_on)
      else $error("second gate on without fets");
   in1_lock_a: assert property (abs1_reg |-> !input1_gate_driver_on)
      else $error("first gate on without fets");
   option_write_a: assert property (opt_wr_s |=> light_load_pulse_mode_off == $past(reg_wdata[4], 3)
      && ship_exit_hold_time == $past(reg_wdata[3], 3) && out_of_audio_off == $past(reg_wdata[0], 3))
      else $error("option outputs differ from write");
   inpath_write_a: assert property (inp_wr_s |=> switching_rate_select == $past(reg_wdata[5], 3)
      && indicator_pin_off == $past(reg_wdata[4], 3) && rail_short_protect_off == $past(reg_wdata[3], 3)
      && input_overcurrent_protect_on == $past(reg_wdata[0], 3))
      else $error("input path outputs differ from write");
   reset_values_a: assert property (reg_reset ##1 quiet_s |=> input_overcurrent_protect_on
      && !rail_short_protect_off && !indicator_pin_off && !light_load_pulse_mode_off && !ship_exit_hold_time
      && !precharge_dropout_mode_off && !out_of_audio_off)
      else $error("outputs wrong after register reset");
   force_refuse_a: assert property (force_s ##0 !battery_above_minimum |=> !input_measure_req [*4])
      else $error("detection started on low battery");
   force_start_a: assert property (force_s ##0 battery_above_minimum |-> ##[2:4] (converter_halt && input_measure_req))
      else $error("detection did not start");
   req_pulse_a: assert property (input_measure_req |=> !input_measure_req)
      else $error("measure request longer than one cycle");
   done_update_a: assert property (detect_done && converter_halt |-> ##[1:2] input_limit_update)
      else $error("limit update missing after measurement");
   halt_release_a: assert property (input_limit_update |-> ##[0:2] !converter_halt)
      else $error("converter still halted after update");
endmodule : ccr_regs_monitor

bind ccr_regs ccr_regs_monitor ccr_regs_monitor_inst (.clock(clock), .arst_n(arst_n), .reg_reset(reg_reset),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .por_done(por_done),
   .in1_fets_present(in1_fets_present), .in2_fets_present(in2_fets_present),
   .battery_above_minimum(battery_above_minimum), .detect_done(detect_done),
   .gate_driver_master_disable(gate_driver_master_disable), .input1_gate_driver_on(input1_gate_driver_on),
   .input2_gate_driver_on(input2_gate_driver_on), .switching_rate_select(switching_rate_select),
   .indicator_pin_off(indicator_pin_off), .rail_short_protect_off(rail_short_protect_off),
   .input_overcurrent_protect_on(input_overcurrent_protect_on), .light_load_pulse_mode_off(light_load_pulse_mode_off),
   .ship_exit_hold_time(ship_exit_hold_time), .precharge_dropout_mode_off(precharge_dropout_mode_off),
   .out_of_audio_off(out_of_audio_off), .converter_halt(converter_halt), .input_measure_req(input_measure_req),
   .input_limit_update(input_limit_update));

//--- verification/ccr_regs_tb.sv
// self-checking bench for ccr_regs: register traffic against an integer model
// assumes ccr_adc_model at the far side; tick shortened to 10 cycles per ms
`timescale 1ns/1ps
module ccr_regs_tb
   import ccr_pkg::*;
;
   logic clock, arst_n, reg_reset, reg_wr, reg_rd, wd_kick, strap_low_rate, por_done, pres1, pres2;
   logic in1_fets_present, in2_fets_present, battery_above_minimum, detect_done;
   logic converter_halt, input_measure_req, input_limit_update;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, adc_delay, d;
   logic [2:0] wd_period;
   wire logic [10:0] outs;
   ccr_byte_t m12, m13;
   int err_count, n_tests, cyc, seed, i, j, halt_cnt, halt_base;
   localparam int LIMIT = 20000;
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   ccr_regs #(.TICK_CYC(10)) ccr_regs_inst (.clock(clock), .arst_n(arst_n), .reg_reset(reg_reset),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .wd_period(wd_period), .wd_kick(wd_kick), .strap_low_rate(strap_low_rate), .por_done(por_done),
      .in1_fets_present(in1_fets_present), .in2_fets_present(in2_fets_present),
      .battery_above_minimum(battery_above_minimum), .detect_done(detect_done),
      .gate_driver_master_disable(outs[10]), .input1_gate_driver_on(outs[9]), .input2_gate_driver_on(outs[8]),
      .switching_rate_select(outs[7]), .indicator_pin_off(outs[6]), .rail_short_protect_off(outs[5]),
      .input_overcurrent_protect_on(outs[4]), .light_load_pulse_mode_off(outs[3]), .ship_exit_hold_time(outs[2]),
      .precharge_dropout_mode_off(outs[1]), .out_of_audio_off(outs[0]), .converter_halt(converter_halt),
      .input_measure_req(input_measure_req), .input_limit_update(input_limit_update));
   ccr_adc_model ccr_adc_model_inst (.clock(clock), .arst_n(arst_n), .input_measure_req(input_measure_req),
      .delay(adc_delay), .detect_done(detect_done));
   // ****************
   // model and tasks
   // ****************
   // gate bits are stored as written but read back forced off under master disable or absent FETs
   function automatic ccr_byte_t exp13();
      ccr_byte_t r;
      r = m13 & 8'hFB;
      if (m12[7] || !pres2) r[7] = 1'b0;
      if (m12[7] || !pres1) r[6] = 1'b0;
      return r;
   endfunction : exp13
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      ccr_byte_t e;
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
      if (a == 8'h12) m12 = v & 8'h9D;
      if (a == 8'h13) m13 = v & 8'hF9;
      repeat (3) @(posedge clock);
      e = exp13();
      chk(outs, {m12[7], e[6], e[7], e[5], e[4], e[3], e[0], m12[4], m12[3], m12[2], m12[0]});
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      chk({3'h0, reg_rdata}, {3'h0, (a == 8'h12) ? m12 : (a == 8'h13) ? exp13() : 8'h00});
   endtask : rd
   always @(posedge clock) begin
      cyc++;
      if (converter_halt === 1'b1) halt_cnt++;
   end
   initial begin
      {reg_reset, reg_wr, reg_rd, wd_kick, por_done, battery_above_minimum} = '0;
      {arst_n, in2_fets_present, pres1, pres2} = '0;
      {strap_low_rate, in1_fets_present} = 2'b11;
      {reg_addr, reg_wdata, adc_delay, wd_period} = '0;
      seed = 32'h6985;
      // timeout branch lives in this process so the counters keep one driver
      fork
         begin
            wait (cyc == LIMIT);
            err_count++;
            results();
         end
      join_none
      m12 = 8'h00;
      m13 = 8'h01;
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      rd(8'h12);
      rd(8'h13);
      por_done <= 1'b1;
      {pres1, pres2} = 2'b10;
      m13[5] = 1'b1;
      rd(8'h13);
      for (i = 0; i < 30; i++) begin
         d = 8'($random(seed));
         wr(8'h12 + 8'(i % 3), d & 8'hFD);
         rd(8'h12 + 8'(i % 3));
      end
      wr(8'h12, 8'h9D);
      wr(8'h13, 8'hF9);
      @(posedge clock);
      reg_reset <= 1'b1;
      @(posedge clock);
      reg_reset <= 1'b0;
      m12 = m12 & 8'h80;
      m13 = (m13 & 8'hE0) | 8'h01;
      rd(8'h12);
      rd(8'h13);
      // 0.5 s code is 500 ticks, 5000 cycles here
      wr(8'h12, 8'h1D);
      wr(8'h13, 8'h19);
      wd_period <= 3'h1;
      wd_kick <= 1'b1;
      @(posedge clock);
      wd_kick <= 1'b0;
      repeat (4000) @(posedge clock);
      wd_kick <= 1'b1;
      @(posedge clock);
      wd_kick <= 1'b0;
      repeat (2000) @(posedge clock);
      rd(8'h12);
      repeat (4000) @(posedge clock);
      m12[2] = 1'b0;
      m13[4] = 1'b0;
      // unmapped write leaves the bank alone, so the output check sees the expiry itself
      wr(8'h14, 8'h00);
      rd(8'h13);
      rd(8'h12);
      wd_period <= 3'h0;
      for (i = 0; i < 3; i++) begin
         battery_above_minimum <= (i != 0);
         adc_delay <= (i == 2) ? 8'h14 : 8'h00;
         halt_base = halt_cnt;
         wr(8'h13, m13 | 8'h02);
         for (j = 0; j < 100 && converter_halt !== 1'b0; j++) @(posedge clock);
         chk({10'h000, halt_cnt != halt_base}, {10'h000, i != 0});
         rd(8'h13);
      end
      arst_n <= 1'b0;
      por_done <= 1'b0;
      {strap_low_rate, in1_fets_present, in2_fets_present} <= 3'b001;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      por_done <= 1'b1;
      {pres1, pres2} = 2'b01;
      m12 = 8'h00;
      m13 = 8'h01;
      rd(8'h13);
      wr(8'h13, 8'hC1);
      rd(8'h13);
      wr(8'h12, 8'h80);
      rd(8'h13);
      results();
   end
endmodule : ccr_regs_tb
